// [bist_pkg.sv]
// Constants and carrier types for the serial-lane self-test block.
// Assumes a 10-bit symbol datapath, one symbol per core clock.
package bist_pkg;
    localparam logic [7:0]  ADDR_GEN_CTL   = 8'h1c;
    localparam logic [7:0]  ADDR_CHK_CTL   = 8'h2c;
    localparam logic [7:0]  ADDR_PHASE_ERR = 8'h30;
    localparam logic [7:0]  ADDR_SCOPE_FI  = 8'h34;
    localparam logic [7:0]  ADDR_LANE_CTL  = 8'h40;
    localparam int GEN_WORD_LSB   = 20;
    localparam int GEN_INJECT_BIT = 19;
    localparam int GEN_MODE_LSB   = 16;
    localparam int CHK_SYNC_BIT   = 3;
    localparam int CNT_LSB_HI     = 16;
    localparam int SC_SAMPLE_BIT_POSITION_LSB    = 27;
    localparam int SC_SKIP_LSB    = 18;
    localparam int SC_MODE_LSB    = 16;
    localparam int PH_VAL_LSB     = 17;
    localparam int SCALE_SHIFT    = 7;
    localparam logic [31:0] GEN_CTL_RESET  = 32'h0000_0000;
    localparam logic [31:0] SCOPE_RESET    = 32'h0000_0000;
    localparam logic [14:0] CNT_MAX        = 15'h7fff;
    localparam logic [9:0]  ALL_ONES       = 10'h3ff;
    typedef enum {GEN_OFF, GEN_L15, GEN_L7, GEN_FIXED, GEN_BAL, GEN_FOUR,
                  GEN_RSV} gen_mode_t;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } reg_req_t;
    typedef struct packed {
        logic [14:0] count;
        logic        scale;
        logic [6:0]  pre;
    } err_cnt_t;
endpackage

// [serdes_bist.sv]
// Serial-lane pattern generator, matcher, error counters and scope.
// Assumes symbol-rate datapath on core_clk_i and same-clock register port.
// Behaviour
// - Gen mode 1 emits LFSR15 X^15+X^14+1; mode 0 disables
// - Gen mode 2 emits LFSR7 X^7+X^6+1
// - Mode 3 repeats user word; mode 4 alternates word and complement
// - Mode 5 cycles zeros, word, ones, complement; 6 and 7 reserved
// - User word sits at bits 29:20, used in modes 3 to 5
// - Writing inject bit flips exactly one output LSB once
// - Matcher mode picks LFSR15, LFSR7, repeat-10 or inverse-10 check
// - While sync set, matcher LFSR loads from received data
// - 15-bit error count at 30:16; scale bit 31 means units of 128
// - Scale set and count at maximum flags overflow; never wraps
// - Phase value at 27:17 with dither bit 16
// - Second error counter at 14:0 with scale bit 15, same behaviour
// - Scope mode 0 off, 1 every 10 bits, 2 every 11+10*skip
// - Scope mode 3 samples every 12+10*skip bits
// - Bits 30:27 pick sampled position in every-10 mode
// - Skip field 26:18 gives symbols skipped between samples
// - Frequency offset signed at 13:1, 1.526 ppm per unit
// - Bit 0 holds frequency dither bit
// - Counters undefined at reset; gen and scope controls reset zero
// - Lane control inverts rx/tx data and forces rx/tx to zero
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module serdes_bist #(
    parameter int SYM_W = 10
) (
    // Clock and reset
    input  wire logic             core_clk_i,
    input  wire logic             reset_i,
    // Register port
    input  wire bist_pkg::reg_req_t req_i,
    output logic [31:0]           rdata_o,
    // Lane datapath
    output logic [SYM_W-1:0]      tx_sym_o,
    input  wire logic [SYM_W-1:0] rx_sym_i,
    output logic                  scope_bit_o,
    output logic                  scope_valid_o,
    // Recovery loop readouts and phase-path error events
    input  wire logic [10:0]      phase_sel_i,
    input  wire logic             phase_dither_i,
    input  wire logic [12:0]      freq_offset_i,
    input  wire logic             freq_dither_i,
    input  wire logic [SYM_W-1:0] phase_err_i
);
    // Datapath functions are unrolled for exactly ten bits
    if (SYM_W != 10)
    begin : g_bad_width
        $error("serdes_bist supports only a 10-bit symbol");
    end

    // Control registers
    logic [31:0] gen_ctl_r;
    logic [3:0]  chk_ctl_r;
    logic [16:0] scope_ctl_r;
    logic [3:0]  lane_ctl_r;
    logic        inject_r;
    bist_pkg::err_cnt_t chk_cnt_r;
    bist_pkg::err_cnt_t ph_cnt_r;

    wire [9:0] user_pattern_word = gen_ctl_r[29:20];
    wire [2:0] gen_mode          = gen_ctl_r[18:16];
    wire [2:0] chk_mode          = chk_ctl_r[2:0];
    wire       chk_sync          = chk_ctl_r[bist_pkg::CHK_SYNC_BIT];
    wire [3:0] sample_bit_position = scope_ctl_r[16:13];
    wire [8:0] skip_count        = scope_ctl_r[12:4];
    wire [1:0] scope_mode        = scope_ctl_r[1:0];
    wire       inv_rx  = lane_ctl_r[3];
    wire       inv_tx  = lane_ctl_r[2];
    wire       zero_rx = lane_ctl_r[1];
    wire       zero_tx = lane_ctl_r[0];

    // Ten-step LFSR advance; bit 0 of result is first bit on the line
    function automatic logic [24:0] lfsr_step(input logic [14:0] s,
                                              input logic        l7);
        logic [14:0] st;
        logic [9:0]  o;
        logic        fb;
        st = s;
        o  = 10'h000;
        for (int i = 0; i < 10; i++)
        begin
            fb   = l7 ? (st[6] ^ st[5]) : (st[14] ^ st[13]);
            o[i] = fb;
            st   = {st[13:0], fb};
        end
        return {st, o};
    endfunction

    function automatic logic [14:0] lfsr_load(input logic [9:0] d,
                                              input logic [14:0] s);
        logic [14:0] st;
        st = s;
        for (int i = 0; i < 10; i++)
            st = {st[13:0], d[i]};
        return st;
    endfunction

    // Saturating counter with times-128 scaling once the field fills
    function automatic bist_pkg::err_cnt_t cnt_add(bist_pkg::err_cnt_t c,
                                                  input logic [3:0] n);
        bist_pkg::err_cnt_t r;
        logic [7:0] p;
        logic [15:0] s;
        r = c;
        if (!c.scale)
        begin
            s = {1'b0, c.count} + {12'h000, n};
            if (s[15])
            begin
                r.scale = 1'b1;
                r.count = {6'h00, s[15:7]};
                r.pre   = s[6:0];
            end
            else
                r.count = s[14:0];
        end
        else if (c.count != bist_pkg::CNT_MAX)
        begin
            p = {1'b0, c.pre} + {4'h0, n};
            r.pre = p[6:0];
            if (p[7])
                r.count = c.count + 15'h0001;
        end
        return r;
    endfunction

    // Generator
    logic [14:0] gen_lfsr_r;
    logic [1:0]  gen_phase_r;
    wire  [24:0] gen_step = lfsr_step(gen_lfsr_r, gen_mode == 3'h2);
    wire  [9:0]  gen_l    = gen_step[9:0];
    wire  [9:0]  gen_four = gen_phase_r == 2'h0 ? 10'h000 :
                            gen_phase_r == 2'h1 ? user_pattern_word :
                            gen_phase_r == 2'h2 ? bist_pkg::ALL_ONES :
                            ~user_pattern_word;
    wire  [9:0]  gen_bal  = gen_phase_r[0] ? ~user_pattern_word
                                           : user_pattern_word;
    wire  [9:0]  gen_sym  = (gen_mode == 3'h1 || gen_mode == 3'h2) ? gen_l :
                            gen_mode == 3'h3 ? user_pattern_word :
                            gen_mode == 3'h4 ? gen_bal :
                            gen_mode == 3'h5 ? gen_four : 10'h000;
    wire  [9:0]  gen_err  = gen_sym ^ {9'h000, inject_r};
    wire  [9:0]  tx_nxt   = zero_tx ? 10'h000
                          : (inv_tx ? ~gen_err : gen_err);
    wire  [14:0] gen_seed = gen_lfsr_r == 15'h0000 ? 15'h0001 : gen_step[24:10];

    // Matcher
    wire  [9:0]  rx_d     = zero_rx ? 10'h000
                          : (inv_rx ? ~rx_sym_i : rx_sym_i);
    logic [14:0] chk_lfsr_r;
    logic [9:0]  rx_prev_r;
    wire  [24:0] chk_step = lfsr_step(chk_lfsr_r, chk_mode == 3'h2);
    wire  [9:0]  chk_mis  = (chk_mode == 3'h1 || chk_mode == 3'h2) ?
                            (chk_step[9:0] ^ rx_d) :
                            chk_mode == 3'h3 ? (rx_d ^ rx_prev_r) :
                            chk_mode == 3'h4 ? ~(rx_d ^ rx_prev_r) :
                            10'h000;
    wire         chk_on   = chk_mode != 3'h0 && chk_mode < 3'h5 && !chk_sync;
    function automatic logic [3:0] popc(input logic [9:0] v);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 10; i++)
            n = n + {3'h0, v[i]};
        return n;
    endfunction
    wire  [3:0]  chk_n    = chk_on ? popc(chk_mis) : 4'h0;
    wire  [3:0]  ph_n     = popc(phase_err_i);

    // Scope sampler: bit counter over the stream
    logic [13:0] sc_cnt_r;
    logic [3:0]  sc_pos_r;
    wire  [13:0] sc_period = scope_mode == 2'h2 ? 14'd11 + 14'd10 * skip_count
                                                : 14'd12 + 14'd10 * skip_count;
    wire  [13:0] sc_rem    = sc_period - sc_cnt_r;
    wire         sc_hit    = scope_mode[1] && sc_rem <= 14'd10;
    wire  [3:0]  sc_idx    = scope_mode == 2'h1 ? sample_bit_position
                                                : sc_rem[3:0] - 4'h1;
    wire         sc_fire   = scope_mode == 2'h1
                             ? sample_bit_position < 4'd10 : sc_hit;
    wire  [13:0] sc_cnt_nxt = sc_hit ? 14'd10 - sc_rem : sc_cnt_r + 14'd10;
    // Skip shrunk mid-run: restart rather than wait out a wrapped remainder
    wire         sc_over    = sc_cnt_r >= sc_period;

    // Register writes
    wire wr_gen   = req_i.wr && req_i.addr == bist_pkg::ADDR_GEN_CTL;
    wire wr_chk   = req_i.wr && req_i.addr == bist_pkg::ADDR_CHK_CTL;
    wire wr_ph    = req_i.wr && req_i.addr == bist_pkg::ADDR_PHASE_ERR;
    wire wr_sc    = req_i.wr && req_i.addr == bist_pkg::ADDR_SCOPE_FI;
    wire wr_lane  = req_i.wr && req_i.addr == bist_pkg::ADDR_LANE_CTL;
    wire bist_pkg::err_cnt_t chk_upd = cnt_add(chk_cnt_r, chk_n);
    wire bist_pkg::err_cnt_t ph_upd  = cnt_add(ph_cnt_r, ph_n);

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            gen_ctl_r   <= bist_pkg::GEN_CTL_RESET;
            scope_ctl_r <= 17'h00000;
            chk_ctl_r   <= 4'h0;
            lane_ctl_r  <= 4'h0;
            inject_r    <= 1'b0;
        end
        else
        begin
            if (wr_gen)
                gen_ctl_r <= {2'h0, req_i.wdata[29:16], 16'h0000};
            if (wr_chk)
                chk_ctl_r <= req_i.wdata[3:0];
            if (wr_sc)
                scope_ctl_r <= {req_i.wdata[30:18], 2'h0, req_i.wdata[17:16]};
            if (wr_lane)
                lane_ctl_r <= req_i.wdata[3:0];
            inject_r <= wr_gen && req_i.wdata[bist_pkg::GEN_INJECT_BIT];
        end
    end

    // Datapath; counters deliberately not reset
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            gen_lfsr_r  <= 15'h0001;
            gen_phase_r <= 2'h0;
            chk_lfsr_r  <= 15'h0001;
            rx_prev_r   <= 10'h000;
            sc_cnt_r    <= 14'h0000;
            tx_sym_o    <= 10'h000;
            scope_bit_o <= 1'b0;
            scope_valid_o <= 1'b0;
        end
        else
        begin
            gen_lfsr_r  <= gen_seed;
            gen_phase_r <= gen_phase_r + 2'h1;
            tx_sym_o    <= tx_nxt;
            rx_prev_r   <= rx_d;
            chk_lfsr_r  <= chk_sync ? lfsr_load(rx_d, chk_lfsr_r)
                                    : chk_step[24:10];
            sc_cnt_r    <= (scope_mode[1] && !sc_over) ? sc_cnt_nxt
                                                      : 14'h0000;
            scope_valid_o <= sc_fire;
            scope_bit_o <= sc_fire ? rx_d[sc_idx] : scope_bit_o;
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (wr_chk)
            chk_cnt_r <= {req_i.wdata[30:16], req_i.wdata[31], 7'h00};
        else
            chk_cnt_r <= chk_upd;
        if (wr_ph)
            ph_cnt_r <= {req_i.wdata[14:0], req_i.wdata[15], 7'h00};
        else
            ph_cnt_r <= ph_upd;
    end

    // Read mux
    wire [31:0] rd_gen = gen_ctl_r;
    wire [31:0] rd_chk = {chk_cnt_r.scale, chk_cnt_r.count, 12'h000, chk_ctl_r};
    wire [31:0] rd_ph  = {4'h0, phase_sel_i, phase_dither_i,
                          ph_cnt_r.scale, ph_cnt_r.count};
    wire [31:0] rd_sc  = {1'b0, scope_ctl_r[16:4], scope_ctl_r[1:0], 2'h0,
                          freq_offset_i, freq_dither_i};
    wire [31:0] rd_sel = req_i.addr == bist_pkg::ADDR_GEN_CTL   ? rd_gen :
                         req_i.addr == bist_pkg::ADDR_CHK_CTL   ? rd_chk :
                         req_i.addr == bist_pkg::ADDR_PHASE_ERR ? rd_ph  :
                         req_i.addr == bist_pkg::ADDR_SCOPE_FI  ? rd_sc  :
                         req_i.addr == bist_pkg::ADDR_LANE_CTL
                             ? {28'h0000000, lane_ctl_r} : 32'h0000_0000;

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            rdata_o <= 32'h0000_0000;
        else
            rdata_o <= req_i.rd ? rd_sel : 32'h0000_0000;
    end

    // Checks
    a_inject_once: assert property (@(posedge core_clk_i) disable iff (reset_i)
        inject_r |=> !inject_r)
        else $error("inject held more than one symbol");
    a_fixed_word: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (gen_mode == 3'h3 && !inject_r && !zero_tx && !inv_tx && !wr_gen
         && !wr_lane) |=> tx_sym_o == user_pattern_word)
        else $error("fixed word not emitted");
    a_gen_off: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (gen_mode == 3'h0 && !inv_tx && !inject_r) |=> tx_sym_o == 10'h000)
        else $error("disabled generator not quiet");
    a_zero_tx: assert property (@(posedge core_clk_i) disable iff (reset_i)
        zero_tx |=> tx_sym_o == 10'h000)
        else $error("zero tx ignored");
    a_no_wrap: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (chk_cnt_r.scale && chk_cnt_r.count == bist_pkg::CNT_MAX && !wr_chk)
        |=> chk_cnt_r.count == bist_pkg::CNT_MAX)
        else $error("error count wrapped");
    a_count_step: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (!chk_cnt_r.scale && chk_cnt_r.count < 15'h7000 && !wr_chk)
        |=> chk_cnt_r.count == $past(chk_cnt_r.count) + {11'h000, $past(chk_n)})
        else $error("error count off");
    a_sync_quiet: assert property (@(posedge core_clk_i) disable iff (reset_i)
        chk_sync |-> chk_n == 4'h0)
        else $error("errors counted while syncing");
    a_ph_no_wrap: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (ph_cnt_r.scale && ph_cnt_r.count == bist_pkg::CNT_MAX && !wr_ph)
        |=> ph_cnt_r.scale && ph_cnt_r.count == bist_pkg::CNT_MAX)
        else $error("phase counter wrapped");
    a_scope_off: assert property (@(posedge core_clk_i) disable iff (reset_i)
        scope_mode == 2'h0 |=> !scope_valid_o)
        else $error("scope sampled while off");

    // Injection: one write gives one corrupted symbol, then clean again
    sequence s_inject_req;
        wr_gen && req_i.wdata[bist_pkg::GEN_INJECT_BIT];
    endsequence
    sequence s_inject_pulse;
        inject_r ##1 !inject_r;
    endsequence
    a_inject_path: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        s_inject_req ##1 !wr_gen |-> s_inject_pulse)
        else $error("inject pulse wrong");

    // Entering scaled mode: count restarts near full/128
    a_scale_enter: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        (!chk_cnt_r.scale && chk_upd.scale && !wr_chk)
        |=> chk_cnt_r.count <= 15'h0101)
        else $error("scaled count too large");
    a_ph_scale_in: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        (!ph_cnt_r.scale && ph_upd.scale && !wr_ph)
        |=> ph_cnt_r.count <= 15'h0101)
        else $error("phase scaled count too large");
    a_ph_step: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        (!ph_cnt_r.scale && ph_cnt_r.count < 15'h7000 && !wr_ph)
        |=> ph_cnt_r.count == $past(ph_cnt_r.count) + {11'h000, $past(ph_n)})
        else $error("phase error count off");
    a_chk_off: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        chk_mode == 3'h0 |-> chk_n == 4'h0)
        else $error("errors counted while matcher off");

    // Read data only in the cycle after a read strobe
    a_rd_idle: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        !req_i.rd |=> rdata_o == 32'h0000_0000)
        else $error("read data without read");

    // Scope every-10 mode samples the chosen position each symbol
    a_scope_every: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        (scope_mode == 2'h1 && sample_bit_position < 4'd10)
        |=> scope_valid_o)
        else $error("scope missed a symbol");
    a_scope_pick: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        (scope_mode == 2'h1 && sample_bit_position < 4'd10)
        |=> scope_bit_o == $past(rx_d[sample_bit_position]))
        else $error("scope sampled wrong position");

    // Lane polarity and four-symbol pattern start
    a_inv_tx: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        (inv_tx && !zero_tx) |=> tx_sym_o == ~$past(gen_err))
        else $error("tx inversion ignored");
    a_four_zero: assert property (
        @(posedge core_clk_i) disable iff (reset_i)
        (gen_mode == 3'h5 && gen_phase_r == 2'h0 && !inject_r && !inv_tx
         && !zero_tx) |=> tx_sym_o == 10'h000)
        else $error("four-symbol pattern lost zero symbol");
endmodule
`default_nettype wire

// [lane_far_end.sv]
// Far-side lane model: transmit loops back to receive, fixed readouts.
// Assumes the bench raises err_mask_i for one cycle per error burst.
`timescale 1ns/1ns
`default_nettype none
module lane_far_end #(
    parameter logic [10:0] PHASE = 11'h5a3,
    parameter logic [12:0] FREQ  = 13'h1f37
) (
    // Clock
    input  wire logic       core_clk_i,
    // Lane
    input  wire logic [9:0] tx_sym_i,
    output logic [9:0]      rx_sym_o,
    // Recovery loop readouts
    output logic [10:0]     phase_sel_o,
    output logic            phase_dither_o,
    output logic [12:0]     freq_offset_o,
    output logic            freq_dither_o,
    // Phase-path error events
    input  wire logic [9:0] err_mask_i,
    output logic [9:0]      phase_err_o
);
    initial
    begin
        rx_sym_o    = 10'h000;
        phase_err_o = 10'h000;
    end
    // One symbol of wire delay, as a real loop adds
    always @(posedge core_clk_i)
    begin
        rx_sym_o    <= tx_sym_i;
        phase_err_o <= err_mask_i;
    end
    assign phase_sel_o    = PHASE;
    assign phase_dither_o = 1'b1;
    assign freq_offset_o  = FREQ;
    assign freq_dither_o  = 1'b1;
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the serial-lane self-test block.
// Assumes the lane model loops transmit symbols back to receive.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam logic [9:0]  WORD  = 10'h2b5;
    localparam logic [10:0] PHASE = 11'h5a3;
    localparam logic [12:0] FREQ  = 13'h1f37;
    logic               core_clk_i = 1'b0;
    logic               reset_i    = 1'b1;
    bist_pkg::reg_req_t req        = '0;
    logic [9:0]         err_mask   = 10'h000;
    logic [31:0]        rdata;
    logic [9:0]         tx_sym, rx_sym, phase_err;
    logic               scope_bit, scope_valid, ph_dith, fr_dith;
    logic [10:0]        ph_sel;
    logic [12:0]        fr_off;
    int                 error_cnt   = 0;
    int                 check_count = 0;

    always #20 core_clk_i = ~core_clk_i;

    serdes_bist u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i),
        .req_i(req), .rdata_o(rdata), .tx_sym_o(tx_sym), .rx_sym_i(rx_sym),
        .scope_bit_o(scope_bit), .scope_valid_o(scope_valid),
        .phase_sel_i(ph_sel), .phase_dither_i(ph_dith),
        .freq_offset_i(fr_off), .freq_dither_i(fr_dith),
        .phase_err_i(phase_err));
    lane_far_end #(.PHASE(PHASE), .FREQ(FREQ)) u_far (
        .core_clk_i(core_clk_i), .tx_sym_i(tx_sym), .rx_sym_o(rx_sym),
        .phase_sel_o(ph_sel), .phase_dither_o(ph_dith),
        .freq_offset_o(fr_off), .freq_dither_o(fr_dith),
        .err_mask_i(err_mask), .phase_err_o(phase_err));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk_i);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk_i);
        req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(posedge core_clk_i);
        req.rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Live fields may tear; read until two reads agree
    task automatic rd2(input logic [7:0] a, output logic [31:0] d);
        logic [31:0] p;
        rd(a, p);
        rd(a, d);
        for (int i = 0; i < 4 && p !== d; i++)
        begin
            p = d;
            rd(a, d);
        end
    endtask
    task automatic gen(input int m, input logic inj);
        wr(bist_pkg::ADDR_GEN_CTL, {2'b00, WORD, inj, 3'(m), 16'h0000});
    endtask
    task automatic pulse(input logic [9:0] m);
        @(posedge core_clk_i) err_mask <= m;
        @(posedge core_clk_i) err_mask <= 10'h000;
        tick(4);
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    function automatic logic [9:0] next_sym(input int m, input logic [9:0] c);
        case (m)
            0: return 10'h000;
            3: return WORD;
            4: return ~c;
            default: return (c == 10'h000) ? WORD : (c == WORD) ? 10'h3ff :
                            (c == 10'h3ff) ? ~WORD : 10'h000;
        endcase
    endfunction

    task automatic t_reset();
        logic [31:0] d;
        check({22'h0, tx_sym}, 32'h0);
        rd(bist_pkg::ADDR_GEN_CTL, d);
        check(d, bist_pkg::GEN_CTL_RESET);
        rd2(bist_pkg::ADDR_SCOPE_FI, d);
        check(d, {18'h0, FREQ, 1'b1});
        rd(8'h3c, d);
        check(d, 32'h0);
        done("reset");
    endtask
    task automatic t_gen_word(input int m);
        logic [9:0] p, c;
        gen(m, 1'b0);
        tick(3);
        p = tx_sym;
        for (int i = 0; i < 8; i++)
        begin
            tick(1);
            c = tx_sym;
            check({22'h0, c}, {22'h0, next_sym(m, p)});
            p = c;
        end
        done("word modes");
    endtask
    task automatic t_lfsr(input int m, input int ta, input int tb);
        logic [39:0] s;
        int          bad;
        gen(m, 1'b0);
        tick(4);
        for (int i = 0; i < 4; i++)
        begin
            tick(1);
            s[i*10 +: 10] = tx_sym;
        end
        bad = (s == 40'h0) ? 1 : 0;
        for (int n = tb; n < 40; n++)
            if (s[n] !== (s[n-ta] ^ s[n-tb]))
                bad++;
        check(32'(bad), 32'h0);
        done("lfsr");
    endtask
    // One injected bit costs one error in LFSR modes, two in repeat modes
    task automatic t_match(input int m, input logic [31:0] inc);
        logic [31:0] d;
        gen(m, 1'b0);
        wr(bist_pkg::ADDR_CHK_CTL, 32'(m) | 32'h8);
        tick(4);
        wr(bist_pkg::ADDR_CHK_CTL, 32'(m));
        tick(12);
        wr(bist_pkg::ADDR_CHK_CTL, 32'(m));
        tick(30);
        rd2(bist_pkg::ADDR_CHK_CTL, d);
        check(d, 32'(m));
        gen(m, 1'b1);
        tick(30);
        rd2(bist_pkg::ADDR_CHK_CTL, d);
        check(d, 32'(m) + inc);
        done("matcher");
    endtask
    task automatic t_sat();
        logic [31:0] d;
        wr(bist_pkg::ADDR_CHK_CTL, 32'hffff_0003);
        gen(3, 1'b1);
        tick(30);
        rd2(bist_pkg::ADDR_CHK_CTL, d);
        check(d, 32'hffff_0003);
        done("saturation");
    endtask
    task automatic t_scale();
        logic [31:0] d;
        wr(bist_pkg::ADDR_CHK_CTL, 32'h7ffe_0003);
        gen(3, 1'b1);
        tick(30);
        rd2(bist_pkg::ADDR_CHK_CTL, d);
        check(d, 32'h8100_0003);
        done("scaling");
    endtask
    task automatic t_phase();
        logic [31:0] d, hi;
        hi = {4'h0, PHASE, 1'b1, 16'h0000};
        wr(bist_pkg::ADDR_PHASE_ERR, 32'h0);
        pulse(10'h124);
        rd2(bist_pkg::ADDR_PHASE_ERR, d);
        check(d, hi | 32'h3);
        wr(bist_pkg::ADDR_PHASE_ERR, 32'h0000_ffff);
        pulse(10'h3ff);
        rd2(bist_pkg::ADDR_PHASE_ERR, d);
        check(d, hi | 32'hffff);
        done("phase");
    endtask
    task automatic t_scope_sample_bit_position(input int b);
        int hits;
        gen(3, 1'b0);
        wr(bist_pkg::ADDR_SCOPE_FI, {1'b0, 4'(b), 9'h0, 2'b01, 16'h0});
        tick(4);
        hits = 0;
        for (int i = 0; i < 20; i++)
        begin
            tick(1);
            if (scope_valid === 1'b1 && scope_bit === WORD[b])
                hits++;
        end
        check(32'(hits), 32'd20);
        done("scope position");
    endtask
    // Stepped sample spacing is approximate, so allow one sample slack
    task automatic t_scope_step(input int md, input int skip);
        int n, exp;
        wr(bist_pkg::ADDR_SCOPE_FI, {5'h0, 9'(skip), 2'(md), 16'h0});
        tick(20);
        n = 0;
        for (int i = 0; i < 1100; i++)
        begin
            tick(1);
            n += (scope_valid === 1'b1);
        end
        exp = (md == 0) ? 0 : 11000 / (9 + md + 10 * skip);
        check(32'(n >= exp - 1 && n <= exp + 1), 32'h1);
        done("scope spacing");
    endtask
    task automatic t_lane();
        gen(3, 1'b0);
        wr(bist_pkg::ADDR_LANE_CTL, 32'h4);
        tick(3);
        check({22'h0, tx_sym}, {22'h0, ~WORD});
        wr(bist_pkg::ADDR_LANE_CTL, 32'h1);
        tick(3);
        check({22'h0, tx_sym}, 32'h0);
        wr(bist_pkg::ADDR_LANE_CTL, 32'h0);
        done("lane control");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (20) @(posedge core_clk_i);
        reset_i <= 1'b0;
        tick(1);
        t_reset();
        t_gen_word(0);
        t_gen_word(3);
        t_gen_word(4);
        t_gen_word(5);
        t_lfsr(1, 14, 15);
        t_lfsr(2, 6, 7);
        t_match(1, 32'h0001_0000);
        t_match(2, 32'h0001_0000);
        t_match(3, 32'h0002_0000);
        t_match(4, 32'h0002_0000);
        t_sat();
        t_scale();
        t_phase();
        t_scope_sample_bit_position(2);
        t_scope_sample_bit_position(3);
        t_scope_step(0, 0);
        t_scope_step(1, 0);
        t_scope_step(2, 2);
        t_scope_step(3, 1);
        t_lane();
        give_verdict();
    end
    initial
    begin
        repeat (20000) @(posedge core_clk_i);
        error_cnt++;
        give_verdict();
    end
endmodule
`default_nettype wire
